// ---- rtl/seepw_slave.sv ----
// Purpose: two-wire serial memory slave front end, write path
// Assumes: bus master drives the clock line; memory array lives outside this block
// Notes: reads are acknowledged on address only; data output is not in this block
`timescale 1ns/1ns
// What this block does
// RULE1: ignore the bus and drive nothing until a start is seen
// RULE2: start is data falling while clock high; detect it
// RULE3: stop is data rising while clock high; ends every operation
// RULE4: data sampled on clock rise, changed only while clock low
// RULE5: pull data low on ninth pulse after each accepted byte
// RULE6: master recovers a hung bus by clocking then issuing start
// RULE7: answer only when top four address bits equal the type code
// RULE8: next two bits must match the two address straps
// RULE9: seventh address-byte bit is memory address bit 16
// RULE10: last bit of address byte: one read, zero write
// RULE11: master sends two address bytes, high byte first
// RULE12: ack address and data bytes; program on the stop
// RULE13: while programming, answer nothing, not even own address
// RULE14: programming is self-timed, clears itself within 5 ms
// RULE15: page write takes up to 256 bytes, each acked
// RULE16: in-page address increments, upper bits fixed, wraps in page
// RULE17: beyond 256 bytes the page address rolls and overwrites
// RULE18: after page stop, program all bytes once, ignoring inputs
// RULE19: write-protect high makes whole array read-only
// RULE20: standby after stop of non-write and after write completes
// RULE21: reset puts the control machine in standby
// RULE22: a new start resets the bus machine
// RULE23: no ack to address while busy, ack once done
// RULE24: address counter holds last address plus one, wraps to zero; here only the low 8 bits wrap, within the page
// RULE25: protected writes still acked but no programming cycle
// RULE26: both lines synchronised and filtered before edge detection
// RULE27: data line is only driven low, open-drain style
module seepw_slave
	import seepw_pkg::*;
#(
	parameter int unsigned PROG_CNT = seepw_pkg::PROG_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic address_strap_low,
	input wire logic address_strap_high,
	input wire logic write_protect,
	output logic [seepw_pkg::ADDR_W-1:0] buf_addr,
	output logic [7:0] buf_data,
	output logic buf_we,
	output logic prog_start,
	output logic [seepw_pkg::ADDR_W-1:0] prog_page,
	output logic busy,
	output logic standby,
	output logic read_req,
	output logic [seepw_pkg::ADDR_W-1:0] addr_counter
);
	import seepw_pkg::*;

	seepw_state_e state;
	logic scl_f, sda_f, scl_d, sda_d;
	logic [2:0] wp_sync;
	logic wp;
	logic start_det, stop_det, scl_rise, scl_fall;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic ack_phase, ack_drive;
	logic write_pending;
	logic got_data;
	logic [31:0] prog_cnt;
	logic next_busy_done;

	// --------------------------------
	// line conditioning
	// --------------------------------
	seepw_line_sync #(.FILT(FILT_LEN), .INIT(1'b1)) u_scl ( // RULE26
		.clk(clk),
		.rst_n(rst_n),
		.line_in(scl_in),
		.line_out(scl_f)
	);

	seepw_line_sync #(.FILT(FILT_LEN), .INIT(1'b1)) u_sda (
		.clk(clk),
		.rst_n(rst_n),
		.line_in(sda_in),
		.line_out(sda_f)
	);

	// write-protect pin: three flops, accepted when last two agree
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wp_sync <= 3'h0;
			wp <= 1'b0;
		end
		else
		begin
			wp_sync <= {wp_sync[1:0], write_protect};
			if (wp_sync[1] == wp_sync[2])
				wp <= wp_sync[2];
		end
	end

	// delayed copies for edge detection
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			scl_d <= scl_f;
			sda_d <= sda_f;
		end
	end

	// --------------------------------
	// bus conditions
	// --------------------------------
	// clock held high on both samples so a data edge is a condition, not a bit
	assign start_det = scl_f && scl_d && sda_d && !sda_f; // RULE2
	assign stop_det = scl_f && scl_d && !sda_d && sda_f; // RULE3
	assign scl_rise = scl_f && !scl_d; // RULE4
	assign scl_fall = !scl_f && scl_d;

	// device address match, shared by the byte decode
	function automatic logic dev_match(input logic [7:0] b, input logic s_hi, input logic s_lo);
		dev_match = (b[7:4] == TYPE_CODE) && (b[3] == s_hi) && (b[2] == s_lo);
	endfunction

	// --------------------------------
	// bit framing
	// --------------------------------
	// bits counted on the clock rise, so the clock fall closing a start is no bit
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			ack_phase <= 1'b0;
		end
		else if (start_det || stop_det)
		begin
			bit_cnt <= 4'h0; // RULE22
			ack_phase <= 1'b0;
		end
		else if (state != SEEPW_IDLE && state != SEEPW_IGNORE)
		begin
			if (scl_rise && !ack_phase)
			begin
				shreg <= {shreg[6:0], sda_f}; // RULE4
				bit_cnt <= bit_cnt + 4'h1;
			end
			if (scl_fall && ack_phase)
				ack_phase <= 1'b0;
			else if (scl_fall && bit_cnt == BIT_LAST + 4'h1)
			begin
				ack_phase <= 1'b1; // eighth bit taken, ninth pulse is the ack slot
				bit_cnt <= 4'h0;
			end
		end
	end

	// byte complete: falling edge after the eighth bit
	logic byte_done;
	assign byte_done = scl_fall && !ack_phase && bit_cnt == BIT_LAST + 4'h1
		&& state != SEEPW_IDLE && state != SEEPW_IGNORE;

	// --------------------------------
	// control state machine
	// --------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state <= SEEPW_IDLE; // RULE21
		else if (start_det)
			state <= SEEPW_DEV; // RULE1 RULE22
		else if (stop_det)
			state <= SEEPW_IDLE;
		else if (byte_done)
		begin
			case (state)
				SEEPW_DEV:
				begin
					// RULE7 RULE8 RULE13 RULE23
					if (!dev_match(shreg, address_strap_high, address_strap_low) || busy)
						state <= SEEPW_IGNORE;
					else if (shreg[0])
						state <= SEEPW_IGNORE; // RULE10: read data path lives elsewhere
					else
						state <= SEEPW_ADDR_HI;
				end
				SEEPW_ADDR_HI: state <= SEEPW_ADDR_LO; // RULE11
				SEEPW_ADDR_LO: state <= SEEPW_DATA;
				SEEPW_DATA: state <= SEEPW_DATA; // RULE15
				default: state <= SEEPW_IGNORE;
			endcase
		end
	end

	// ack decision latched at the end of the byte
	always_ff @(posedge clk)
	begin
		if (!rst_n || start_det || stop_det)
			ack_drive <= 1'b0;
		else if (byte_done)
		begin
			if (state == SEEPW_DEV)
				ack_drive <= dev_match(shreg, address_strap_high, address_strap_low) && !busy; // RULE5 RULE23
			else
				ack_drive <= 1'b1; // RULE12 RULE15 RULE25
		end
		else if (scl_fall && ack_phase)
			ack_drive <= 1'b0;
	end

	// open drain: enable low means pull the line low
	assign sda_out = 1'b0; // RULE27
	assign sda_oe_n = !ack_drive; // RULE27

	// read requests are flagged for the outside data path
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			read_req <= 1'b0;
		else
			read_req <= byte_done && state == SEEPW_DEV && shreg[0] && !busy
				&& dev_match(shreg, address_strap_high, address_strap_low);
	end

	// --------------------------------
	// address counter and page buffer writes
	// --------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			addr_counter <= ADDR_RESET;
		else if (byte_done)
		begin
			case (state)
				SEEPW_DEV:
					if (dev_match(shreg, address_strap_high, address_strap_low) && !busy)
						addr_counter[16] <= shreg[1]; // RULE9
				SEEPW_ADDR_HI: addr_counter[15:8] <= shreg; // RULE11
				SEEPW_ADDR_LO: addr_counter[7:0] <= shreg;
				SEEPW_DATA:
					// RULE16 RULE17 RULE24: low byte wraps, upper bits fixed
					addr_counter[PAGE_BITS-1:0] <= addr_counter[PAGE_BITS-1:0] + 8'h01;
				default: addr_counter <= addr_counter;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			buf_we <= 1'b0;
			buf_addr <= ADDR_RESET;
			buf_data <= 8'h00;
		end
		else
		begin
			buf_we <= byte_done && state == SEEPW_DATA; // RULE15
			if (byte_done && state == SEEPW_DATA)
			begin
				buf_addr <= addr_counter;
				buf_data <= shreg;
			end
		end
	end

	// a write is pending once a data byte is held; cancelled by a fresh start
	always_ff @(posedge clk)
	begin
		if (!rst_n || start_det)
			got_data <= 1'b0;
		else if (byte_done && state == SEEPW_DATA)
			got_data <= 1'b1;
	end
	assign write_pending = got_data && state == SEEPW_DATA;

	// --------------------------------
	// self-timed programming cycle
	// --------------------------------
	assign next_busy_done = busy && prog_cnt >= PROG_CNT - 1;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			busy <= 1'b0;
			prog_cnt <= 32'h0;
			prog_start <= 1'b0;
			prog_page <= ADDR_RESET;
		end
		else
		begin
			prog_start <= 1'b0;
			if (stop_det && write_pending && !wp && !busy)
			begin
				busy <= 1'b1; // RULE12 RULE18 RULE19 RULE25
				prog_cnt <= 32'h0;
				prog_start <= 1'b1;
				prog_page <= {addr_counter[16:PAGE_BITS], 8'h00};
			end
			else if (next_busy_done)
				busy <= 1'b0; // RULE14
			else if (busy)
				prog_cnt <= prog_cnt + 32'h1;
		end
	end

	// --------------------------------
	// standby
	// --------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			standby <= 1'b1; // RULE21
		else if (start_det)
			standby <= 1'b0;
		else if ((stop_det && !(write_pending && !wp)) || next_busy_done)
			standby <= !busy || next_busy_done; // RULE20
	end
endmodule

// ---- rtl/seepw_pkg.sv ----
// Purpose: shared constants for the two-wire serial memory slave write path
// Assumes: 250 MHz system clock
// Notes: times kept in their own unit, cycle counts derived from them
package seepw_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned PROG_TIME_US = 5000; // self-timed write, 5 ms max
	localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_MHZ; // longest time, exact product so nothing rounds
	localparam logic [3:0] TYPE_CODE = 4'ha; // fixed type pattern 1010
	localparam int unsigned ADDR_W = 17;
	localparam int unsigned PAGE_BITS = 8; // 256-byte page
	localparam logic [16:0] ADDR_RESET = 17'h00000;
	localparam int unsigned FILT_LEN = 2; // glitch filter length in samples
	localparam logic [3:0] BIT_LAST = 4'h7;
	typedef enum logic [2:0] {
		SEEPW_IDLE,
		SEEPW_DEV,
		SEEPW_ADDR_HI,
		SEEPW_ADDR_LO,
		SEEPW_DATA,
		SEEPW_IGNORE
	} seepw_state_e;
endpackage

// ---- rtl/seepw_line_sync.sv ----
// Purpose: synchronise and glitch-filter one bus line
// Assumes: line is asynchronous to clk
// Notes: three flops, change taken once second and third agree, then a short filter
`timescale 1ns/1ns
module seepw_line_sync
	import seepw_pkg::*;
#(
	parameter int unsigned FILT = seepw_pkg::FILT_LEN,
	parameter logic INIT = 1'b1
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic line_in,
	output logic line_out
);
	logic [2:0] sync;
	logic [3:0] cnt;
	logic agreed;

	// --------------------------------
	// synchroniser chain
	// --------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sync <= {3{INIT}};
		else
			sync <= {sync[1:0], line_in};
	end

	// only the second and third stages are looked at
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			agreed <= INIT;
		else if (sync[1] == sync[2])
			agreed <= sync[2];
	end

	// filter: new level must hold FILT cycles, spikes are dropped
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			line_out <= INIT;
			cnt <= 4'h0;
		end
		else if (agreed == line_out)
			cnt <= 4'h0;
		else if (cnt >= 4'(FILT - 1))
		begin
			line_out <= agreed; // RULE26
			cnt <= 4'h0;
		end
		else
			cnt <= cnt + 4'h1;
	end
endmodule

// ---- verification/seepw_checker.sv ----
// Purpose: port assertions for the serial memory slave
// Assumes: bound to seepw_slave, one clock domain
// Notes: busy length tracked by a small counter
`timescale 1ns/1ns
module seepw_checker
	import seepw_pkg::*;
#(
	parameter int unsigned PROG_CNT = seepw_pkg::PROG_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic write_protect,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic prog_start,
	input wire logic [seepw_pkg::ADDR_W-1:0] prog_page,
	input wire logic busy,
	input wire logic standby
);
	int unsigned bcnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// length of the current busy run, so the self-clear can be bounded
	always_ff @(posedge clk)
		bcnt <= (!rst_n || !busy) ? 0 : bcnt + 1;
	a_drive_low_only: assert property (sda_out == 1'b0)
		else $error("data line driven high");
	a_reset_idle: assert property ($rose(rst_n) |-> sda_oe_n && !busy && standby)
		else $error("not idle after reset");
	a_ack_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("ack moved while clock high");
	a_prog_busy: assert property (prog_start |=> busy && !standby)
		else $error("no busy after program start");
	a_wp_blocks: assert property (write_protect [*8] |-> !prog_start)
		else $error("program start while protected");
	a_busy_quiet: assert property (busy |-> sda_oe_n)
		else $error("ack while busy");
	a_busy_bound: assert property (busy |-> bcnt < PROG_CNT)
		else $error("busy too long");
	a_busy_full: assert property ($fell(busy) |-> bcnt == PROG_CNT)
		else $error("busy too short");
	a_wake_standby: assert property ($fell(busy) |-> ##[0:2] standby)
		else $error("no standby after write");
	a_page_base: assert property (prog_start |-> prog_page[7:0] == 8'h00)
		else $error("page base not aligned");
endmodule

// ---- verification/seepw_master.sv ----
// Purpose: two-wire bus master model
// Assumes: open-drain bus with pull-up resolved in the bench
// Notes: quarter bit is 10 clocks, so a bit lasts 160 ns
`timescale 1ns/1ns
module seepw_master
(
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_m
);
	// bus idle: both lines released high
	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic q();
		repeat (10) @(negedge clk);
	endtask
	// data falls while clock high
	task automatic start();
		sda_m = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_m = 1'b0;
		q();
		scl = 1'b0;
		q();
	endtask
	// data rises while clock high; clock then stands still
	task automatic stop();
		sda_m = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_m = 1'b1;
		q();
	endtask
	// msb first, data moved only while clock low
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			sda_m = b[i];
			q();
			scl = 1'b1;
			q();
			q();
			scl = 1'b0;
			q();
		end
		sda_m = 1'b1;
		q();
		scl = 1'b1;
		q();
		ack = !sda;
		q();
		scl = 1'b0;
		q();
	endtask
	// clock until data is seen high, then a fresh start
	task automatic recover();
		sda_m = 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			scl = 1'b1;
			q();
			if (sda)
				break;
			scl = 1'b0;
			q();
		end
		start();
	endtask
endmodule

// ---- verification/seepw_slave_test.sv ----
// Purpose: self-checking bench for the slave write path
// Assumes: busy time shortened through PROG_CNT
// Notes: bus resolved here as open drain with pull-up
`timescale 1ns/1ns
module seepw_slave_test;
	import seepw_pkg::*;
	localparam int unsigned PROG_CNT = 1000;
	logic clk = 1'b0, rst_n = 1'b0, s_lo = 1'b0, s_hi = 1'b1, wp = 1'b0;
	logic scl, sda_m, sda, sda_out, sda_oe_n, buf_we, prog_start, busy, standby, read_req, ack;
	logic [16:0] buf_addr, prog_page, addr_counter, last_addr;
	logic [7:0] buf_data, last_data;
	int error_cnt = 0, checks_done = 0, n_we = 0, n_prog = 0, n_rd = 0;
	// low when either party pulls, else the pull-up wins
	assign sda = sda_m & (sda_oe_n | sda_out);
	initial
	begin
		forever #2 clk = ~clk;
	end
	seepw_slave #(.PROG_CNT(PROG_CNT)) seepw_slave_inst (.clk, .rst_n, .scl_in(scl),
		.sda_in(sda), .sda_out, .sda_oe_n, .address_strap_low(s_lo),
		.address_strap_high(s_hi), .write_protect(wp), .buf_addr, .buf_data, .buf_we,
		.prog_start, .prog_page, .busy, .standby, .read_req, .addr_counter);
	seepw_master mst (.clk, .sda, .scl, .sda_m);
	// tally one-cycle pulses and keep the last buffered byte
	always @(posedge clk)
	begin
		if (buf_we === 1'b1)
		begin
			last_addr <= buf_addr;
			last_data <= buf_data;
		end
		n_we <= n_we + (buf_we === 1'b1);
		n_prog <= n_prog + (prog_start === 1'b1);
		n_rd <= n_rd + (read_req === 1'b1);
	end
	task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tx(input logic [7:0] b, input logic exp);
		mst.send(b, ack);
		chk("ack", {16'h0, exp}, {16'h0, ack});
	endtask
	// bounded wait for the write cycle to clear
	task automatic wait_done();
		int i;
		for (i = 0; i < 1200 && busy !== 1'b0; i++)
			@(negedge clk);
		if (i == 1200)
		begin
			chk("busy_wait", 0, {16'h0, busy});
			summarize();
		end
	endtask
	initial
	begin
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		mst.q();
		chk("standby", 1, {16'h0, standby});
		chk("idle_ack", 1, {16'h0, sda_oe_n});
		mst.start();
		tx(8'hb8, 0);
		mst.start();
		tx(8'ha4, 0);
		mst.stop();
		$display("test refuse done");
		mst.start();
		tx(8'haa, 1);
		tx(8'h12, 1);
		tx(8'h34, 1);
		tx(8'h5c, 1);
		mst.stop();
		mst.q();
		chk("wr_addr", 17'h11234, last_addr);
		chk("wr_data", 17'h0005c, {9'h0, last_data});
		chk("busy", 1, {16'h0, busy});
		chk("standby", 0, {16'h0, standby});
		mst.start();
		tx(8'haa, 0);
		mst.stop();
		wait_done();
		chk("standby", 1, {16'h0, standby});
		chk("counter", 17'h11235, addr_counter);
		mst.start();
		tx(8'haa, 1);
		mst.stop();
		$display("test byte write done");
		mst.start();
		tx(8'haa, 1);
		tx(8'h20, 1);
		tx(8'hfe, 1);
		for (int i = 0; i < 3; i++)
			tx(8'(8'h40 + i), 1);
		mst.stop();
		mst.q();
		chk("wrap_addr", 17'h12000, last_addr);
		chk("we_count", 4, 17'(n_we));
		chk("page", 17'h12000, prog_page);
		wait_done();
		chk("counter", 17'h12001, addr_counter);
		$display("test page wrap done");
		wp = 1'b1;
		mst.start();
		tx(8'ha8, 1);
		tx(8'h01, 1);
		tx(8'h02, 1);
		tx(8'h77, 1);
		mst.stop();
		mst.q();
		chk("wp_busy", 0, {16'h0, busy});
		chk("prog_count", 2, 17'(n_prog));
		wp = 1'b0;
		$display("test protect done");
		mst.start();
		tx(8'ha9, 1);
		mst.stop();
		mst.q();
		chk("read_req", 1, 17'(n_rd));
		chk("standby", 1, {16'h0, standby});
		mst.start();
		tx(8'ha8, 1);
		tx(8'h03, 1);
		mst.recover();
		tx(8'ha8, 1);
		mst.stop();
		chk("abort_prog", 2, 17'(n_prog));
		$display("test read and recover done");
		summarize();
	end
endmodule
bind seepw_slave seepw_checker #(.PROG_CNT(PROG_CNT)) seepw_checker_inst (.clk, .rst_n,
	.scl_in, .write_protect, .sda_out, .sda_oe_n, .prog_start, .prog_page, .busy, .standby);
